// *** hdl/host_error_status_bank.v ***
// host error status bank: four sticky error registers and global flag
`include "host_error_regs.vh"
`timescale 1ns/10ps
// Summary of operation
// - zone one error sets bit0, optionally sleep-masked
// - zone two error sets bit1, optionally sleep-masked
// - zones three, four set bits2,3, never masked
// - regulator hot inputs set bits4,5, sleep-masked
// - analog inputs 1-8 errors, always sleep-masked
// - analog 9-16 errors; 9,10,11,15 always masked
// - analog 12-14 masked only when selected
// - analog input 16 never masked
// - diode faults in fourth register, optionally masked
// - fuse inputs flag only in legacy mode
// - core voltage mismatches set bits4,5, masked
// - bits sticky; clear loses to present condition
// - any set bit raises global host flag
// - masking follows sleepDeep input, select inputs
module host_error_status_bank
(
    // clock and reset
    input  wire       clock,
    input  wire       rst,
    // register port
    input  wire [7:0] regAddr,
    input  wire       regWrite,
    input  wire       regRead,
    input  wire [7:0] regWriteData,
    output reg  [7:0] regReadData_q,
    // sleep control
    input  wire       sleepDeep,
    input  wire [7:0] zoneSleepSelect,
    input  wire [7:0] analogSleepSelect,
    input  wire [7:0] diodeSleepSelect,
    // events
    input  wire [3:0] zoneLimitError,
    input  wire       regulator_one_hot_input,
    input  wire       regulator_two_hot_input,
    input  wire [15:0] analogLimitError,
    input  wire [3:0] diodeFault,
    input  wire       fuse_monitor_input_a,
    input  wire       fuse_monitor_input_b,
    input  wire       legacy_six_bit_code_mode,
    input  wire [1:0] coreVoltageMismatch,
    // status
    output reg        hostErrorFlag_q
);
    wire [7:0] zoneRaw;
    wire [7:0] diodeRaw;
    wire [7:0] zoneGated;
    wire [7:0] lowGated;
    wire [7:0] highGated;
    wire [7:0] diodeGated;
    wire [7:0] zoneStatus;
    wire [7:0] lowStatus;
    wire [7:0] highStatus;
    wire [7:0] diodeStatus;
    wire       fuseAEvent;
    wire       fuseBEvent;
    reg  [7:0] readMux;

    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    assign fuseAEvent = fuse_monitor_input_a & legacy_six_bit_code_mode;
    assign fuseBEvent = fuse_monitor_input_b & legacy_six_bit_code_mode;
    assign zoneRaw = {2'h0, regulator_two_hot_input, regulator_one_hot_input, zoneLimitError};
    assign diodeRaw = {diodeFault[3], diodeFault[2], coreVoltageMismatch, fuseBEvent, fuseAEvent,
                       diodeFault[1], diodeFault[0]};

    // zone: 0,1 optional; 2,3 never; 4,5 always
    sleep_event_gate zoneGate
    (
        .rawEvent       (zoneRaw),
        .alwaysMask     (8'h30),
        .optionalMask   (8'h03),
        .optionalSelect (zoneSleepSelect),
        .deepSleep      (sleepDeep),
        .gatedEvent     (zoneGated)
    );
    sleep_event_gate lowGate
    (
        .rawEvent       (analogLimitError[7:0]),
        .alwaysMask     (8'hFF),
        .optionalMask   (8'h00),
        .optionalSelect (8'h00),
        .deepSleep      (sleepDeep),
        .gatedEvent     (lowGated)
    );
    sleep_event_gate highGate
    (
        .rawEvent       (analogLimitError[15:8]),
        .alwaysMask     (8'h47),
        .optionalMask   (8'h38),
        .optionalSelect (analogSleepSelect),
        .deepSleep      (sleepDeep),
        .gatedEvent     (highGated)
    );
    sleep_event_gate diodeGate
    (
        .rawEvent       (diodeRaw),
        .alwaysMask     (8'h3C),
        .optionalMask   (8'hC3),
        .optionalSelect (diodeSleepSelect),
        .deepSleep      (sleepDeep),
        .gatedEvent     (diodeGated)
    );

    w1c_status_reg zoneReg
    (
        .clock     (clock),
        .rst       (rst),
        .writeHit  (regWrite & hit(regAddr, `HOST_ERROR_ZONE_REGULATOR_OFS)),
        .writeData (regWriteData),
        .implMask  (`ZONE_REG_IMPL_MASK),
        .setEvent  (zoneGated),
        .status_q  (zoneStatus)
    );
    w1c_status_reg lowReg
    (
        .clock     (clock),
        .rst       (rst),
        .writeHit  (regWrite & hit(regAddr, `HOST_ERROR_ANALOG_LOW_OFS)),
        .writeData (regWriteData),
        .implMask  (8'hFF),
        .setEvent  (lowGated),
        .status_q  (lowStatus)
    );
    w1c_status_reg highReg
    (
        .clock     (clock),
        .rst       (rst),
        .writeHit  (regWrite & hit(regAddr, `HOST_ERROR_ANALOG_HIGH_OFS)),
        .writeData (regWriteData),
        .implMask  (8'hFF),
        .setEvent  (highGated),
        .status_q  (highStatus)
    );
    w1c_status_reg diodeReg
    (
        .clock     (clock),
        .rst       (rst),
        .writeHit  (regWrite & hit(regAddr, `HOST_ERROR_DIODE_SUPPLY_OFS)),
        .writeData (regWriteData),
        .implMask  (8'hFF),
        .setEvent  (diodeGated),
        .status_q  (diodeStatus)
    );

    always @*
    begin
        readMux = 8'h00;
        if (hit(regAddr, `HOST_ERROR_ZONE_REGULATOR_OFS))
            readMux = zoneStatus;
        else if (hit(regAddr, `HOST_ERROR_ANALOG_LOW_OFS))
            readMux = lowStatus;
        else if (hit(regAddr, `HOST_ERROR_ANALOG_HIGH_OFS))
            readMux = highStatus;
        else if (hit(regAddr, `HOST_ERROR_DIODE_SUPPLY_OFS))
            readMux = diodeStatus;
    end

    always @(posedge clock)
    begin
        if (rst)
        begin
            regReadData_q   <= 8'h00;
            hostErrorFlag_q <= 1'b0;
        end
        else
        begin
            if (regRead)
                regReadData_q <= readMux;
            hostErrorFlag_q <= |{zoneStatus, lowStatus, highStatus, diodeStatus};
        end
    end
endmodule

// *** hdl/host_error_regs.vh ***
// offsets, bit positions and reset values of the host error status bank
`ifndef HOST_ERROR_REGS_VH
`define HOST_ERROR_REGS_VH
`define HOST_ERROR_ZONE_REGULATOR_OFS 8'h48
`define HOST_ERROR_ANALOG_LOW_OFS     8'h49
`define HOST_ERROR_ANALOG_HIGH_OFS    8'h4A
`define HOST_ERROR_DIODE_SUPPLY_OFS   8'h4B
`define HOST_ERROR_RESET              8'h00
`define ZONE_REG_IMPL_MASK            8'h3F
`define ZONE_ONE_BIT                  0
`define ZONE_TWO_BIT                  1
`define ZONE_THREE_BIT                2
`define ZONE_FOUR_BIT                 3
`define REG_ONE_HOT_BIT               4
`define REG_TWO_HOT_BIT               5
`define DIODE_1B_BIT                  0
`define DIODE_2B_BIT                  1
`define FUSE_A_BIT                    2
`define FUSE_B_BIT                    3
`define CORE_ONE_BIT                  4
`define CORE_TWO_BIT                  5
`define DIODE_1A_BIT                  6
`define DIODE_2A_BIT                  7
`endif

// *** hdl/sleep_event_gate.v ***
// gates raw error events by sleep state and mask selection
`timescale 1ns/10ps
module sleep_event_gate
(
    // events and policy
    input  wire [7:0] rawEvent,
    input  wire [7:0] alwaysMask,
    input  wire [7:0] optionalMask,
    input  wire [7:0] optionalSelect,
    // sleep state
    input  wire       deepSleep,
    output wire [7:0] gatedEvent
);
    // bit masked when asleep and either always or optionally selected
    assign gatedEvent = rawEvent & ~({8{deepSleep}} & (alwaysMask | (optionalMask & optionalSelect)));
endmodule

// *** hdl/w1c_status_reg.v ***
// one sticky write-one-to-clear status register
`include "host_error_regs.vh"
`timescale 1ns/10ps
module w1c_status_reg
(
    // clock and reset
    input  wire       clock,
    input  wire       rst,
    // access
    input  wire       writeHit,
    input  wire [7:0] writeData,
    input  wire [7:0] implMask,
    // events
    input  wire [7:0] setEvent,
    output reg  [7:0] status_q
);
    reg [7:0] status_d;
    always @*
    begin
        status_d = status_q;
        if (writeHit)
            status_d = status_d & ~writeData;
        status_d = (status_d | setEvent) & implMask;
    end
    always @(posedge clock)
    begin
        if (rst)
            status_q <= `HOST_ERROR_RESET;
        else
            status_q <= status_d;
    end
endmodule

// *** verif/host_error_status_bank_sva.sv ***
// concurrent checks on the host error status bank ports
`timescale 1ns/10ps
module host_error_status_bank_sva
(
    // clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // register port
    input wire logic [7:0]  regAddr,
    input wire logic        regRead,
    input wire logic        regWrite,
    input wire logic [7:0]  regReadData_q,
    // sleep, events and status
    input wire logic        sleepDeep,
    input wire logic [7:0]  zoneSleepSelect,
    input wire logic [3:0]  zoneLimitError,
    input wire logic        regulator_one_hot_input,
    input wire logic [15:0] analogLimitError,
    input wire logic        hostErrorFlag_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    chk_zone_one_awake: assert property (!sleepDeep && zoneLimitError[0] |-> ##2 hostErrorFlag_q)
        else $error("zone one event lost");
    chk_zone_two_unselected: assert property (sleepDeep && !zoneSleepSelect[1] && zoneLimitError[1] |-> ##2 hostErrorFlag_q)
        else $error("unselected zone two event masked");
    chk_zone_far_kept: assert property (zoneLimitError[3:2] != 2'b00 |-> ##2 hostErrorFlag_q)
        else $error("zone three or four event masked");
    chk_regulator_awake: assert property (!sleepDeep && regulator_one_hot_input |-> ##2 hostErrorFlag_q)
        else $error("regulator hot event lost");
    chk_analog_low_awake: assert property (!sleepDeep && analogLimitError[7:0] != 8'h00 |-> ##2 hostErrorFlag_q)
        else $error("low analog event lost");
    chk_analog_top_kept: assert property (analogLimitError[15] |-> ##2 hostErrorFlag_q)
        else $error("analog sixteen event masked");
    chk_reserved_zero: assert property (regRead && regAddr == 8'h48 |=> regReadData_q[7:6] == 2'b00)
        else $error("reserved bits read nonzero");
    chk_flag_sticky: assert property (hostErrorFlag_q && !regWrite && !$past(regWrite) |=> hostErrorFlag_q)
        else $error("flag dropped without a clear");
    cover property (sleepDeep && analogLimitError != 16'h0000);
    cover property (regWrite && zoneLimitError != 4'h0);
    cover property ($fell(hostErrorFlag_q));
endmodule
bind host_error_status_bank host_error_status_bank_sva u_sva
(
    .clock, .rst, .regAddr, .regRead, .regWrite, .regReadData_q, .sleepDeep,
    .zoneSleepSelect, .zoneLimitError, .regulator_one_hot_input, .analogLimitError, .hostErrorFlag_q
);

// *** verif/host_sw_model.sv ***
// host software model: register writes and reads
`timescale 1ns/10ps
module host_sw_model
(
    // clock
    input wire logic        clock,
    // register port
    output logic [7:0]      regAddr,
    output logic            regWrite,
    output logic            regRead,
    output logic [7:0]      regWriteData,
    input wire logic [7:0]  regReadData_q
);
    initial
    begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWriteData = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regWriteData = d;
        regWrite = 1'b1;
        @(negedge clock);
        regWrite = 1'b0;
        regWriteData = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clock);
        regRead = 1'b0;
        d = regReadData_q;
    endtask
endmodule

// *** verif/tb_host_error_status_bank.sv ***
// self-checking bench for the host error status bank
`timescale 1ns/10ps
module tb_host_error_status_bank;
    typedef struct packed {logic [30:0] ev; logic slp; logic [23:0] sel; logic [7:0] a; logic [7:0] x;} row_t;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  regAddr, regWriteData, regReadData_q, rdata;
    logic        regWrite, regRead, hostErrorFlag_q;
    logic [30:0] ev = 31'h0;
    logic        sleepDeep = 1'b0;
    logic [23:0] sel = 24'h0;
    int          errors = 0, checked = 0, cycles = 0;
    row_t        rows [12] = '{'{31'h3F, 1'b0, 24'h0, 8'h48, 8'h3F}, '{31'h3F, 1'b1, 24'h0, 8'h48, 8'h0F},
        '{31'h3F, 1'b1, 24'h3, 8'h48, 8'h0C}, '{31'h15, 1'b0, 24'h0, 8'h48, 8'h15},
        '{31'h3FC0, 1'b0, 24'h0, 8'h49, 8'hFF}, '{31'h3FC0, 1'b1, 24'h0, 8'h49, 8'h00},
        '{31'h3FC000, 1'b1, 24'h0, 8'h4A, 8'hB8}, '{31'h3FC000, 1'b1, 24'h3800, 8'h4A, 8'h80},
        '{31'h7FC00000, 1'b0, 24'h0, 8'h4B, 8'hFF}, '{31'h6D400000, 1'b0, 24'h0, 8'h4B, 8'h71},
        '{31'h7FC00000, 1'b1, 24'h0, 8'h4B, 8'hC3}, '{31'h7FC00000, 1'b1, 24'hC30000, 8'h4B, 8'h00}};
    always #50 clock = ~clock;
    host_error_status_bank u_dut
    (
        .clock, .rst, .regAddr, .regWrite, .regRead, .regWriteData, .regReadData_q, .sleepDeep,
        .zoneSleepSelect(sel[7:0]), .analogSleepSelect(sel[15:8]), .diodeSleepSelect(sel[23:16]),
        .zoneLimitError(ev[3:0]), .regulator_one_hot_input(ev[4]), .regulator_two_hot_input(ev[5]),
        .analogLimitError(ev[21:6]), .diodeFault(ev[25:22]), .fuse_monitor_input_a(ev[26]),
        .fuse_monitor_input_b(ev[27]), .legacy_six_bit_code_mode(ev[28]), .coreVoltageMismatch(ev[30:29]),
        .hostErrorFlag_q
    );
    host_sw_model host (.clock, .regAddr, .regWrite, .regRead, .regWriteData, .regReadData_q);
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            errors++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (4) @(negedge clock);
        rst = 1'b0;
        for (logic [7:0] a = 8'h48; a < 8'h4C; a++)
        begin
            host.rd(a, rdata);
            cmp(rdata, 8'h00);
        end
        cmp({7'h00, hostErrorFlag_q}, 8'h00);
        foreach (rows[i])
        begin
            @(negedge clock);
            {ev, sleepDeep, sel} = {rows[i].ev, rows[i].slp, rows[i].sel};
            @(negedge clock);
            {ev, sleepDeep, sel} = 56'h0;
            host.rd(rows[i].a, rdata);
            cmp(rdata, rows[i].x);
            cmp({7'h00, hostErrorFlag_q}, {7'h00, rows[i].x != 8'h00});
            for (logic [7:0] a = 8'h48; a < 8'h4C; a++)
                host.wr(a, 8'hFF);
            $display("row %0d done", i);
        end
        // clear attempt while zone three still out of limits
        ev = 31'h4;
        host.wr(8'h48, 8'h04);
        host.wr(8'h48, 8'h00);
        ev = 31'h0;
        host.rd(8'h48, rdata);
        cmp(rdata, 8'h04);
        host.wr(8'h48, 8'h04);
        host.rd(8'h48, rdata);
        cmp(rdata, 8'h00);
        cmp({7'h00, hostErrorFlag_q}, 8'h00);
        ev = 31'h40;
        host.wr(8'h4C, 8'hFF);
        ev = 31'h0;
        host.rd(8'h4C, rdata);
        cmp(rdata, 8'h00);
        host.rd(8'h49, rdata);
        cmp(rdata, 8'h01);
        // mid-run reset wipes a set bit and the flag
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        host.rd(8'h49, rdata);
        cmp(rdata, 8'h00);
        cmp({7'h00, hostErrorFlag_q}, 8'h00);
        $display("hand tests done");
        tally_and_finish;
    end
endmodule
